// File: design/sccg_top.sv
// Local design decision: the APB slave port.
`timescale 1ns/1ps
// System clock selection, fast clock selection and module clock gating.
module sccg_top (
  // APB clock, reset and freeze.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Source clock levels.
  input  wire logic        internal_fast_rc_clock,
  input  wire logic        internal_slow_rc_clock,
  input  wire logic        crystal_clock,
  input  wire logic        doubled_crystal_clock,
  // Generated clocks.
  output logic             sys_clk,
  output logic             high_speed_clock,
  output logic             slow_clk,
  output logic             timer_fast_clk,
  // Gated module clocks.
  output logic      [7:0]  gated_clk_a,
  output logic      [7:0]  gated_clk_b,
  output logic      [7:0]  gated_clk_c,
  // Clock output pins.
  output logic             pa7_out,
  output logic             pa7_oe,
  output logic             pa1_out,
  output logic             pa1_oe
);
  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  gate_a;    // Module clock gate A.
    logic [7:0]  gate_b;    // Module clock gate B.
    logic [7:0]  gate_c;    // Module clock gate C.
    logic [7:0]  sys_sel;   // System source and divider.
    logic [7:0]  hsc_hi;    // Fast clock select high bit.
    logic [7:0]  pin_mux;   // Pin function select.
    logic [7:0]  pin_a8;    // Pin 1 function.
    logic [7:0]  pin_a9;    // Pin 7 function.
    logic [31:0] rdata;     // Read data captured in setup.
    logic        err;       // Unmapped address seen in setup.
    logic [1:0]  sys_cur;   // System source now in use.
    logic        sys;       // System clock level.
    logic [1:0]  hsc_cur;   // Fast clock source now in use.
    logic        hsc;       // Fast clock level.
    logic        pa7;       // Pin 7 level.
    logic        pa7_en;    // Pin 7 drive.
    logic        pa1;       // Pin 1 level.
    logic        pa1_en;    // Pin 1 drive.
  } sccg_top_st_t;

  sccg_top_st_t st_q;       // Registered state.
  sccg_top_st_t st_d;       // Next state.
  logic [11:0]  idx;        // Word index of the access.
  logic         hit;        // Address is mapped.
  logic [7:0]   rd_mux;     // Register selected for read.
  logic         wr_en;      // Write takes effect now.
  logic [1:0]   sys_req;    // Requested system source.
  logic [1:0]   hsc_req;    // Requested fast clock source.
  logic [4:0]   div_val;    // Programmable divider value.
  logic [4:0]   div_eff;    // Divider value with zero made one.
  logic [7:0]   src_b;      // Clock behind each gate B bit.
  logic [7:0]   src_c;      // Clock behind each gate C bit.

  // ----------------------------------------------------------------
  // Dividers.
  // ----------------------------------------------------------------
  sccg_div_if div1_if ();   // Programmable divider.
  sccg_div_if div2_if ();   // Fixed two-thirds divider.
  sccg_div_if tmr_if ();    // Timer fast clock divider.

  // The programmable divider counts 2N edges per period, high for N.
  assign div_val        = st_q.sys_sel[sccg_pkg::DIV_HI:0];
  assign div_eff        = (div_val == 5'h00) ? 5'h01 : div_val;
  assign div1_if.src    = st_q.hsc;
  assign div1_if.period = {div_eff, 1'b0};
  assign div1_if.high   = {1'b0, div_eff};
  assign div2_if.src    = st_q.hsc;
  assign div2_if.period = sccg_pkg::TWO3_PERIOD;
  assign div2_if.high   = sccg_pkg::TWO3_HIGH;
  assign tmr_if.src     = crystal_clock;
  assign tmr_if.period  = sccg_pkg::TWO3_PERIOD;
  assign tmr_if.high    = sccg_pkg::TWO3_HIGH;

  sccg_div u_div1 (.pclk(pclk), .presetn(presetn), .ce(ce), .d(div1_if.div));
  sccg_div u_div2 (.pclk(pclk), .presetn(presetn), .ce(ce), .d(div2_if.div));
  sccg_div u_tmr  (.pclk(pclk), .presetn(presetn), .ce(ce), .d(tmr_if.div));

  // ----------------------------------------------------------------
  // Address decode and read mux.
  // ----------------------------------------------------------------
  assign idx   = paddr[13:2];
  assign wr_en = psel && penable && pwrite && ce;

  // Pick the addressed register; unused bits read as zero.
  always_comb begin
    hit    = 1'b1;
    rd_mux = 8'h00;
    case (idx)
      sccg_pkg::IDX_GATE_A:  rd_mux = st_q.gate_a & sccg_pkg::MSK_GATE_A;
      sccg_pkg::IDX_GATE_B:  rd_mux = st_q.gate_b;
      sccg_pkg::IDX_GATE_C:  rd_mux = st_q.gate_c & sccg_pkg::MSK_GATE_C;
      sccg_pkg::IDX_SYS_SEL: rd_mux = st_q.sys_sel;
      sccg_pkg::IDX_HSC_HI:  rd_mux = st_q.hsc_hi & sccg_pkg::MSK_HSC_HI;
      sccg_pkg::IDX_PIN_MUX: rd_mux = st_q.pin_mux;
      sccg_pkg::IDX_PIN_A8:  rd_mux = st_q.pin_a8;
      sccg_pkg::IDX_PIN_A9:  rd_mux = st_q.pin_a9;
      default:               hit    = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Source requests.
  // ----------------------------------------------------------------
  assign sys_req = st_q.sys_sel[sccg_pkg::SRC_HI:sccg_pkg::SRC_LO];
  // Both 1x codes fold into one crystal code, so flipping the low bit starts no switch.
  assign hsc_req = st_q.hsc_hi[0] ? 2'h2 : {1'b0, st_q.sys_sel[sccg_pkg::HSC_LO]};

  // Level of a system source by code.
  function automatic logic sys_src(input logic [1:0] code, input logic rc, input logic hs,
                                   input logic d1, input logic d2);
    logic v;
    case (code)
      sccg_pkg::SYS_RC:   v = rc;
      sccg_pkg::SYS_HSC:  v = hs;
      sccg_pkg::SYS_DIV1: v = d1;
      default:            v = d2;
    endcase
    return v;
  endfunction

  // Level of a fast clock source by code; both 1x codes mean crystal.
  function automatic logic hsc_src(input logic [1:0] code, input logic dbl, input logic rc,
                                   input logic xtal);
    logic v;
    case (code)
      sccg_pkg::HSC_DBL: v = dbl;
      sccg_pkg::HSC_RC:  v = rc;
      default:           v = xtal;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic: registers, clock switches and pins.
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    // Capture read data and the error flag in the setup phase.
    if (psel && !penable) begin
      st_d.rdata = {24'h00_0000, rd_mux};
      st_d.err   = !hit;
    end
    // Writes land in the access phase; unmapped writes are dropped.
    if (wr_en && hit) begin
      case (idx)
        sccg_pkg::IDX_GATE_A:  st_d.gate_a  = pwdata[7:0];
        sccg_pkg::IDX_GATE_B:  st_d.gate_b  = pwdata[7:0];
        sccg_pkg::IDX_GATE_C:  st_d.gate_c  = pwdata[7:0];
        sccg_pkg::IDX_SYS_SEL: st_d.sys_sel = pwdata[7:0];
        sccg_pkg::IDX_HSC_HI:  st_d.hsc_hi  = pwdata[7:0];
        sccg_pkg::IDX_PIN_MUX: st_d.pin_mux = pwdata[7:0];
        sccg_pkg::IDX_PIN_A8:  st_d.pin_a8  = pwdata[7:0];
        sccg_pkg::IDX_PIN_A9:  st_d.pin_a9  = pwdata[7:0];
        default:               st_d.err     = 1'b1;
      endcase
    end
    // Fast clock switch: finish the old high phase, hold low, join new low.
    if (hsc_req == st_q.hsc_cur) begin
      st_d.hsc = hsc_src(st_q.hsc_cur, doubled_crystal_clock,
                         internal_fast_rc_clock, crystal_clock);
    end else if (st_q.hsc) begin
      st_d.hsc = hsc_src(st_q.hsc_cur, doubled_crystal_clock,
                         internal_fast_rc_clock, crystal_clock);
    end else begin
      st_d.hsc = 1'b0;
      if (!hsc_src(hsc_req, doubled_crystal_clock, internal_fast_rc_clock, crystal_clock)) begin
        st_d.hsc_cur = hsc_req;
      end
    end
    // System clock switch with the same low-phase handover.
    if (sys_req == st_q.sys_cur) begin
      st_d.sys = sys_src(st_q.sys_cur, internal_fast_rc_clock, st_q.hsc,
                         div1_if.clk_out, div2_if.clk_out);
    end else if (st_q.sys) begin
      st_d.sys = sys_src(st_q.sys_cur, internal_fast_rc_clock, st_q.hsc,
                         div1_if.clk_out, div2_if.clk_out);
    end else begin
      st_d.sys = 1'b0;
      if (!sys_src(sys_req, internal_fast_rc_clock, st_q.hsc,
                   div1_if.clk_out, div2_if.clk_out)) begin
        st_d.sys_cur = sys_req;
      end
    end
    // Pin 7 carries the fast RC clock while the system runs from it.
    st_d.pa7_en = (st_q.pin_mux == sccg_pkg::PIN7_MUX_VAL) &&
                  (st_q.pin_a9 == sccg_pkg::PIN7_FN_VAL) &&
                  (st_q.sys_cur == sccg_pkg::SYS_RC);
    st_d.pa7    = st_d.pa7_en & internal_fast_rc_clock;
    // Pin 1 carries the slow RC clock.
    st_d.pa1_en = (st_q.pin_mux == sccg_pkg::PIN1_MUX_VAL) &&
                  (st_q.pin_a8 == sccg_pkg::PIN1_FN_VAL);
    st_d.pa1    = st_d.pa1_en & internal_slow_rc_clock;
  end

  // ----------------------------------------------------------------
  // State register; low enable freezes everything.
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q         <= '0;
      st_q.gate_a  <= sccg_pkg::RST_GATE_A;
      st_q.gate_b  <= sccg_pkg::RST_GATE_B;
      st_q.gate_c  <= sccg_pkg::RST_GATE_C;
      st_q.sys_sel <= sccg_pkg::RST_SYS_SEL;
      st_q.hsc_hi  <= sccg_pkg::RST_HSC_HI;
      st_q.pin_mux <= sccg_pkg::RST_PIN;
      st_q.pin_a8  <= sccg_pkg::RST_PIN;
      st_q.pin_a9  <= sccg_pkg::RST_PIN;
      st_q.sys_cur <= sccg_pkg::SYS_RC;
      st_q.hsc_cur <= sccg_pkg::HSC_DBL;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Module clock gates.
  // ----------------------------------------------------------------
  // Gate B bit 6 and gate C bits 0 and 1 carry the slow clock.
  always_comb begin
    src_b                        = {8{st_q.sys}};
    src_b[sccg_pkg::TMR_SLOW_BIT] = internal_slow_rc_clock;
    src_c                        = {8{st_q.sys}};
    src_c[sccg_pkg::QD_SLOW_BIT]  = internal_slow_rc_clock;
    src_c[sccg_pkg::PWM_SLOW_BIT] = internal_slow_rc_clock;
  end

  for (genvar i = 0; i < 8; i++) begin : g_gate
    sccg_gate u_ga (.pclk(pclk), .presetn(presetn), .ce(ce), .src(st_q.sys),
                    .en(st_q.gate_a[i] & sccg_pkg::MSK_GATE_A[i]), .gclk(gated_clk_a[i]));
    sccg_gate u_gb (.pclk(pclk), .presetn(presetn), .ce(ce), .src(src_b[i]),
                    .en(st_q.gate_b[i]), .gclk(gated_clk_b[i]));
    sccg_gate u_gc (.pclk(pclk), .presetn(presetn), .ce(ce), .src(src_c[i]),
                    .en(st_q.gate_c[i] & sccg_pkg::MSK_GATE_C[i]), .gclk(gated_clk_c[i]));
  end

  // The timer fast clock shares gate B bit 0 with the timer system clock.
  sccg_gate u_gtmr (.pclk(pclk), .presetn(presetn), .ce(ce), .src(tmr_if.clk_out),
                    .en(st_q.gate_b[sccg_pkg::TMR_FAST_BIT]), .gclk(timer_fast_clk));

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  assign prdata           = st_q.rdata;
  assign pready           = 1'b1;
  assign pslverr          = psel && penable && st_q.err;
  assign sys_clk          = st_q.sys;
  assign high_speed_clock = st_q.hsc;
  assign slow_clk         = internal_slow_rc_clock;
  assign pa7_out          = st_q.pa7;
  assign pa7_oe           = st_q.pa7_en;
  assign pa1_out          = st_q.pa1;
  assign pa1_oe           = st_q.pa1_en;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  a_sys_rc_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_q.sys_cur == sccg_pkg::SYS_RC && sys_req == sccg_pkg::SYS_RC
    |=> sys_clk == $past(internal_fast_rc_clock))
    else $error("System clock does not follow fast RC.");
  a_sys_div1_sel: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_q.sys_cur == sccg_pkg::SYS_DIV1 && sys_req == sccg_pkg::SYS_DIV1
    |=> sys_clk == $past(div1_if.clk_out))
    else $error("System clock does not follow divider one.");
  a_sys_div2_sel: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_q.sys_cur == sccg_pkg::SYS_DIV2 && sys_req == sccg_pkg::SYS_DIV2
    |=> sys_clk == $past(div2_if.clk_out))
    else $error("System clock does not follow two-thirds clock.");
  a_hsc_xtal_sel: assert property (@(posedge pclk) disable iff (!presetn)
    ce && hsc_req[1] && st_q.hsc_cur[1] |=> high_speed_clock == $past(crystal_clock))
    else $error("Fast clock does not follow crystal.");
  a_reset_rc_src: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> sys_req == sccg_pkg::SYS_RC && st_q.sys_cur == sccg_pkg::SYS_RC)
    else $error("System clock is not on fast RC after reset.");
  a_pin7_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_q.pin_mux == sccg_pkg::PIN7_MUX_VAL && st_q.pin_a9 == sccg_pkg::PIN7_FN_VAL
    && st_q.sys_cur == sccg_pkg::SYS_RC |=> pa7_oe && pa7_out == $past(internal_fast_rc_clock))
    else $error("Pin 7 does not carry fast RC.");
  a_pin1_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_q.pin_mux == sccg_pkg::PIN1_MUX_VAL && st_q.pin_a8 == sccg_pkg::PIN1_FN_VAL
    |=> pa1_oe && pa1_out == $past(internal_slow_rc_clock))
    else $error("Pin 1 does not carry slow RC.");
  a_switch_low: assert property (@(posedge pclk) disable iff (!presetn)
    ce && sys_req != st_q.sys_cur && !st_q.sys |=> !sys_clk)
    else $error("System clock rose during a source switch.");
endmodule

// File: design/sccg_pkg.sv
package sccg_pkg;
  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_GATE_A   = 12'h0063;  // Module clock gate A.
  localparam logic [11:0] IDX_GATE_B   = 12'h0064;  // Module clock gate B.
  localparam logic [11:0] IDX_GATE_C   = 12'h0065;  // Module clock gate C.
  localparam logic [11:0] IDX_SYS_SEL  = 12'h0066;  // System clock source and divider.
  localparam logic [11:0] IDX_HSC_HI   = 12'h0070;  // Fast clock select high bit.
  localparam logic [11:0] IDX_PIN_MUX  = 12'h0586;  // Port A pin function select.
  localparam logic [11:0] IDX_PIN_A8   = 12'h05a8;  // Pin 1 clock output function.
  localparam logic [11:0] IDX_PIN_A9   = 12'h05a9;  // Pin 7 clock output function.
  // ----------------------------------------------------------------
  // Values after reset and readable bit masks.
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_GATE_A  = 8'h13;
  localparam logic [7:0] RST_GATE_B  = 8'h80;
  localparam logic [7:0] RST_GATE_C  = 8'h10;
  localparam logic [7:0] RST_SYS_SEL = 8'h06;
  localparam logic [7:0] RST_HSC_HI  = 8'h00;
  localparam logic [7:0] RST_PIN     = 8'h00;
  localparam logic [7:0] MSK_GATE_A  = 8'hf7;  // Bit 3 is unused.
  localparam logic [7:0] MSK_GATE_C  = 8'h33;  // Bits 2, 3, 6 and 7 are unused.
  localparam logic [7:0] MSK_HSC_HI  = 8'h01;  // Only bit 0 exists.
  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int SRC_HI = 6;  // System source field top bit.
  localparam int SRC_LO = 5;  // System source field bottom bit.
  localparam int DIV_HI = 4;  // Divider field top bit.
  localparam int HSC_LO = 7;  // Low select bit inside the system register.
  localparam int TMR_FAST_BIT = 0;  // Gate B timer fast and system clocks.
  localparam int TMR_SLOW_BIT = 6;  // Gate B timer slow clock.
  localparam int QD_SLOW_BIT  = 0;  // Gate C decoder slow clock.
  localparam int PWM_SLOW_BIT = 1;  // Gate C PWM slow clock.
  // ----------------------------------------------------------------
  // Source codes.
  // ----------------------------------------------------------------
  localparam logic [1:0] SYS_RC   = 2'h0;
  localparam logic [1:0] SYS_HSC  = 2'h1;
  localparam logic [1:0] SYS_DIV1 = 2'h2;
  localparam logic [1:0] SYS_DIV2 = 2'h3;
  localparam logic [1:0] HSC_DBL  = 2'h0;
  localparam logic [1:0] HSC_RC   = 2'h1;
  // ----------------------------------------------------------------
  // Pin function values and fixed divider shape.
  // ----------------------------------------------------------------
  localparam logic [7:0] PIN7_MUX_VAL = 8'h7f;
  localparam logic [7:0] PIN7_FN_VAL  = 8'h40;
  localparam logic [7:0] PIN1_MUX_VAL = 8'hfd;
  localparam logic [7:0] PIN1_FN_VAL  = 8'h08;
  localparam logic [5:0] TWO3_PERIOD  = 6'h03;  // Three source edges per output period.
  localparam logic [5:0] TWO3_HIGH    = 6'h02;  // High for two of them.
endpackage

// File: design/sccg_div_if.sv
`timescale 1ns/1ps
// Carries the edge-count shape of a divider and its output level.
interface sccg_div_if;
  logic       src;      // Source clock level.
  logic [5:0] period;   // Output period in source edges.
  logic [5:0] high;     // Edges for which the output stays high.
  logic       clk_out;  // Divided clock level.
  modport ctl (output src, output period, output high, input clk_out);
  modport div (input src, input period, input high, output clk_out);
endinterface

// File: design/sccg_div.sv
`timescale 1ns/1ps
// Edge-counting divider: counts both edges of the source level.
module sccg_div (
  // Clock, reset and enable.
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Divider shape and output.
  sccg_div_if.div   d
);
  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       prev;  // Source level seen last cycle.
    logic [5:0] cnt;   // Source edges within the output period.
    logic       out;   // Divided clock.
  } sccg_div_st_t;

  sccg_div_st_t st_q;  // Registered state.
  sccg_div_st_t st_d;  // Next state.
  logic [5:0]   per;   // Period, never below one edge.

  // A zero period would stall the counter, so it counts as one.
  assign per = (d.period == 6'h00) ? 6'h01 : d.period;

  // Advance on every source edge and shape the output from the count.
  always_comb begin
    st_d = st_q;
    if (d.src != st_q.prev) begin
      st_d.cnt = (st_q.cnt + 6'h01 >= per) ? 6'h00 : st_q.cnt + 6'h01;
      st_d.out = (st_d.cnt < d.high);
    end
    st_d.prev = d.src;
  end

  // Register the state; low enable freezes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign d.clk_out = st_q.out;

  // The count stays inside the period while the period holds still.
  a_div_cnt_range: assert property (@(posedge pclk) disable iff (!presetn)
    ce && st_q.cnt < per ##1 $stable(per) |-> st_q.cnt < per)
    else $error("Divider count left its period.");
endmodule

// File: design/sccg_gate.sv
`timescale 1ns/1ps
// Glitch-free gate: the enable is taken only while the source is low.
module sccg_gate (
  // Clock, reset and enable.
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Source, enable and gated clock.
  input  wire logic src,
  input  wire logic en,
  output logic      gclk
);
  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en_l;  // Enable held while the source is high.
    logic out;   // Gated clock.
  } sccg_gate_st_t;

  sccg_gate_st_t st_q;  // Registered state.
  sccg_gate_st_t st_d;  // Next state.

  // Take a new enable only in the low phase so no runt pulse appears.
  always_comb begin
    st_d = st_q;
    if (!src) begin
      st_d.en_l = en;
    end
    st_d.out = src & st_d.en_l;
  end

  // Register the state; low enable freezes it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign gclk = st_q.out;

  // A blocked gate gives no high level on the next cycle.
  a_gate_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    ce && !st_q.en_l && !en |=> !gclk)
    else $error("Gated clock rose while blocked.");
endmodule

// File: verif/sccg_top_tb.sv
`timescale 1ns/1ps
module sccg_top_tb;
  // ---------------------------------------------
  // Stimulus and observed signals.
  // ---------------------------------------------
  typedef struct packed {logic wr; logic [15:0] addr; logic [7:0] val;} sccg_tb_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, pready, pslverr, sys_clk, timer_fast_clk, pa7_out, pa7_oe;
  logic        pa1_out, pa1_oe, e, hsc, slw;
  logic [7:0]  ga, gb, gc;  // Gated module clocks.
  logic [11:0] pv, pp;      // Clock probes and their levels one sample earlier.
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [4:0]  cnt_q = 5'h00;  // Slow source clocks are taken from this counter.
  int          errors = 0, tests_run = 0, n[12];  // n holds rising edges per probe.
  localparam sccg_tb_row_t ROWS[13] = '{'{1'b0, 16'h018c, 8'h13}, '{1'b0, 16'h0190, 8'h80},
    '{1'b0, 16'h0194, 8'h10}, '{1'b0, 16'h0198, 8'h06}, '{1'b0, 16'h01c0, 8'h00},
    '{1'b1, 16'h018c, 8'hff}, '{1'b1, 16'h0194, 8'hff}, '{1'b1, 16'h01c0, 8'hff},
    '{1'b1, 16'h0190, 8'h41}, '{1'b0, 16'h018c, 8'hf7}, '{1'b0, 16'h0194, 8'h33},
    '{1'b0, 16'h01c0, 8'h01}, '{1'b0, 16'h0190, 8'h41}};
  localparam logic [7:0] SEL[5] = '{8'h00, 8'h20, 8'h43, 8'h60, 8'h40};
  localparam int RISES[5] = '{60, 30, 10, 20, 30};
  always #25 pclk = ~pclk;
  always @(posedge pclk) cnt_q <= cnt_q + 5'h01;
  sccg_top sccg_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internal_fast_rc_clock(cnt_q[1]),
    .internal_slow_rc_clock(cnt_q[4]), .crystal_clock(cnt_q[2]),
    .doubled_crystal_clock(cnt_q[3]), .sys_clk(sys_clk), .high_speed_clock(hsc),
    .slow_clk(slw), .timer_fast_clk(timer_fast_clk), .gated_clk_a(ga), .gated_clk_b(gb),
    .gated_clk_c(gc), .pa7_out(pa7_out), .pa7_oe(pa7_oe), .pa1_out(pa1_out), .pa1_oe(pa1_oe));
  // Probes: system, timer, gate B 0, 1, 6, gate C 0, 5, gate A 3, fast, slow, pin 7, pin 1.
  assign pv = {pa1_out, pa7_out, slw, hsc, ga[3], gc[5], gc[0], gb[6], gb[1], gb[0],
               timer_fast_clk, sys_clk};
  // ---------------------------------------------
  // Bus, comparison and closing tasks.
  // ---------------------------------------------
  task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Accepts an edge count within one of the expected figure.
  task near(input int got, input int exp, input string m);
    chk(32'(got > exp + 1 || got + 1 < exp), 32'h0000_0000, m);
  endtask
  task rises();  // Counts rising edges of every probe over 240 cycles.
    pp = pv;
    foreach (n[j]) n[j] = 0;
    repeat (240) begin
      @(negedge pclk);
      foreach (n[j]) n[j] += int'(pv[j] & ~pp[j]);
      pp = pv;
    end
  endtask
  task test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog: the tests need about 3000 cycles.
  initial begin
    #(50 * 8000);
    errors++;
    test_done();
  end
  // ---------------------------------------------
  // Main sequence.
  // ---------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ROWS[i]) begin
      apb(ROWS[i].wr, ROWS[i].addr, ROWS[i].val);
      if (!ROWS[i].wr) chk(r, {24'h00_0000, ROWS[i].val}, "register value");
    end
    $display("test done: registers");
    foreach (SEL[i]) begin
      apb(1'b1, 16'h0198, SEL[i]);
      repeat (20) @(posedge pclk);
      rises();
      near(n[0], RISES[i], "system clock rate");
      if (i == 0) begin
        near(n[1], 20, "timer clock rate");
        near(n[2], 60, "timer system clock gate");
        chk(32'(n[3]), 32'h0000_0000, "blocked gate");
        near(n[4], 8, "timer slow clock gate");
        near(n[5], 8, "decoder slow clock gate");
        near(n[6], 60, "decoder system clock gate");
        chk(32'(n[7]), 32'h0000_0000, "unused gate bit");
        near(n[8], 30, "crystal fast clock");
        near(n[9], 8, "slow clock");
      end
    end
    $display("test done: clock sources");
    apb(1'b1, 16'h01c0, 8'h00);
    apb(1'b1, 16'h0198, 8'h80);
    repeat (20) @(posedge pclk);
    rises();
    near(n[8], 60, "fast RC fast clock");
    apb(1'b1, 16'h0198, 8'h00);
    repeat (20) @(posedge pclk);
    rises();
    near(n[8], 15, "doubled crystal fast clock");
    $display("test done: fast clock sources");
    apb(1'b1, 16'h0198, 8'h00);
    apb(1'b1, 16'h1618, 8'h7f);
    apb(1'b1, 16'h16a4, 8'h40);
    repeat (3) @(posedge pclk);
    chk({31'h0, pa7_oe}, 32'h1, "pin 7 drive");
    rises();
    near(n[10], 60, "pin 7 clock");
    apb(1'b1, 16'h1618, 8'hfd);
    apb(1'b1, 16'h16a0, 8'h08);
    repeat (3) @(posedge pclk);
    chk({30'h0, pa1_oe, pa7_oe}, 32'h2, "pin 1 drive");
    rises();
    near(n[11], 8, "pin 1 clock");
    $display("test done: clock pins");
    apb(1'b0, 16'h0000, 8'h00);
    chk({r[30:0], e}, 32'h1, "unmapped read");
    $display("test done: unmapped");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({29'h0, pa1_oe, gb[0], sys_clk}, 32'h0000_0000, "outputs in reset");
    presetn <= 1'b1;
    apb(1'b0, 16'h0198, 8'h00);
    chk(r, 32'h0000_0006, "system select after reset");
    repeat (20) @(posedge pclk);
    rises();
    near(n[0], 60, "system clock after reset");
    $display("test done: reset");
    test_done();
  end
endmodule
